/* rtl/ahb_word_port.sv */
// AHB-Lite address phase capture for a zero wait state register slave.
// Assumes single word transfers; hready is the slave's own hreadyout.
`timescale 1ns/1ns
module ahb_word_port (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [refmon_pkg::ADDR_W-1:0] haddr,
	input wire logic hready,
	output logic rd_accept,
	output logic wr_pending,
	output logic [refmon_pkg::ADDR_W-1:0] wr_offset
);

	logic addr_accept;
	logic wr_pending_reg;
	logic [refmon_pkg::ADDR_W-1:0] wr_offset_reg;

	// Address phase is taken only for selected word NONSEQ; others are ignored
	assign addr_accept = hsel && hready && (htrans == refmon_pkg::HTRANS_NONSEQ)
		&& (hsize == refmon_pkg::HSIZE_WORD);
	assign rd_accept = addr_accept && !hwrite;

	// Write address waits one cycle for hwdata in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending_reg <= 1'b0;
			wr_offset_reg <= '0;
		end else begin
			wr_pending_reg <= addr_accept && hwrite;
			wr_offset_reg <= haddr;
		end
	end

	assign wr_pending = wr_pending_reg;
	assign wr_offset = wr_offset_reg;

endmodule // ahb_word_port

/* rtl/level_sync.sv */
// Multi-stage synchroniser for one asynchronous level.
// Assumes the input is a slow level from the analog side.
`timescale 1ns/1ns
module level_sync #(
	parameter int STAGES = refmon_pkg::SYNC_STAGES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);

	////////////////////////////////////////////////////////////////////////
	// Fewer than two stages would leave metastability exposed
	generate
		if (STAGES < 2) begin : g_bad
			$error("level_sync needs at least two stages");
		end
	endgenerate

	logic [STAGES-1:0] chain_reg;

	// Shift chain, only the last stage is read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_reg <= '0;
		end else begin
			chain_reg <= {chain_reg[STAGES-2:0], async_in};
		end
	end

	assign sync_out = chain_reg[STAGES-1];

endmodule // level_sync

/* rtl/reference_and_supply_monitor_ctl.sv */
// Control for bandgap, two internal references and the supply droop detector.
// Assumes a single core clock, an AHB-Lite master and asynchronous analog inputs.
`timescale 1ns/1ns
module reference_and_supply_monitor_ctl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] haddr,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic brownout_reset_enable,
	input wire logic bandgap_stable_async,
	input wire logic droop_compare_async,
	input wire logic sleep_active,
	output logic bandgap_enable,
	output logic high_ref_amp_enable,
	output logic low_ref_amp_enable,
	output logic high_ref_pin_out_enable,
	output logic low_ref_pin_out_enable,
	output logic detector_power,
	output logic [3:0] trip_level_select,
	output logic external_trip_select,
	output logic droop_irq,
	output logic wake_request
);

	////////////////////////////////////////////////////////////////////////
	// Bus front end
	logic rd_accept;
	logic wr_pending;
	logic [refmon_pkg::ADDR_W-1:0] wr_offset;
	logic [refmon_pkg::ADDR_W-1:0] rd_offset;

	// Low byte only, so the registers alias every 256 bytes
	assign rd_offset = haddr[refmon_pkg::ADDR_W-1:0];

	ahb_word_port u_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.haddr(rd_offset),
		.hready(hready),
		.rd_accept(rd_accept),
		.wr_pending(wr_pending),
		.wr_offset(wr_offset)
	);

	////////////////////////////////////////////////////////////////////////
	// Analog side inputs
	logic bandgap_stable_status_sync;
	logic cmp_sync;

	level_sync #(.STAGES(refmon_pkg::SYNC_STAGES)) u_bandgap_stable_status_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(bandgap_stable_async),
		.sync_out(bandgap_stable_status_sync)
	);

	level_sync #(.STAGES(refmon_pkg::SYNC_STAGES)) u_cmp_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(droop_compare_async),
		.sync_out(cmp_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic high_en_reg;
	logic high_en_next;
	logic low_en_reg;
	logic low_en_next;
	logic high_oe_reg;
	logic high_oe_next;
	logic low_oe_reg;
	logic low_oe_next;
	logic det_en_reg;
	logic det_en_next;
	logic [3:0] trip_reg;
	logic [3:0] trip_next;
	logic flag_reg;
	logic flag_next;
	logic ie_reg;
	logic ie_next;

	// Write strobes, valid in the data phase while hwdata stands
	logic wr_ref;
	logic wr_lvd;
	logic wr_droop;

	assign wr_ref = wr_pending && (wr_offset == refmon_pkg::OFF_REF_CTRL);
	assign wr_lvd = wr_pending && (wr_offset == refmon_pkg::OFF_LVD_CTRL);
	assign wr_droop = wr_pending && (wr_offset == refmon_pkg::OFF_DROOP_CTRL);

	// Reference control; low nibble has no storage so writes there vanish
	assign high_en_next = wr_ref ? hwdata[refmon_pkg::BIT_HIGH_EN] : high_en_reg;
	assign low_en_next = wr_ref ? hwdata[refmon_pkg::BIT_LOW_EN] : low_en_reg;
	assign high_oe_next = wr_ref ? hwdata[refmon_pkg::BIT_HIGH_OE] : high_oe_reg;
	assign low_oe_next = wr_ref ? hwdata[refmon_pkg::BIT_LOW_OE] : low_oe_reg;

	// Detector control; stable status is read only and not stored here
	assign det_en_next = wr_lvd ? hwdata[refmon_pkg::BIT_DET_EN] : det_en_reg;
	assign trip_next = wr_lvd ?
		hwdata[refmon_pkg::TRIP_LSB +: refmon_pkg::TRIP_W] : trip_reg;

	////////////////////////////////////////////////////////////////////////
	// Droop flag
	logic bandgap_stable_status_status;
	logic droop_set;
	logic droop_clear;

	// Stable status only counts while the bandgap is actually powered
	assign bandgap_stable_status_status = bandgap_stable_status_sync && bandgap_enable;

	// Flag set needs detector on, bandgap stable and supply at or below trip
	assign droop_set = det_en_reg && bandgap_stable_status_status && cmp_sync;

	// Software clears by writing zero to the flag bit; writing one does nothing
	assign droop_clear = wr_droop && !hwdata[refmon_pkg::BIT_FLAG];

	// Set beats clear, so a clear under a live droop leaves the flag up
	assign flag_next = droop_set ? 1'b1 : (droop_clear ? 1'b0 : flag_reg);
	assign ie_next = wr_droop ? hwdata[refmon_pkg::BIT_IE] : ie_reg;

	// Reference enables; everything powered down after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			high_en_reg <= refmon_pkg::ENABLE_RST;
			low_en_reg <= refmon_pkg::ENABLE_RST;
		end else begin
			high_en_reg <= high_en_next;
			low_en_reg <= low_en_next;
		end
	end

	// Pin output enables; stored even while their reference is off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			high_oe_reg <= refmon_pkg::ENABLE_RST;
			low_oe_reg <= refmon_pkg::ENABLE_RST;
		end else begin
			high_oe_reg <= high_oe_next;
			low_oe_reg <= low_oe_next;
		end
	end

	// Detector enable and trip code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			det_en_reg <= refmon_pkg::ENABLE_RST;
			trip_reg <= refmon_pkg::TRIP_RST;
		end else begin
			det_en_reg <= det_en_next;
			trip_reg <= trip_next;
		end
	end

	// Droop flag and its interrupt enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_reg <= refmon_pkg::ENABLE_RST;
			ie_reg <= refmon_pkg::ENABLE_RST;
		end else begin
			flag_reg <= flag_next;
			ie_reg <= ie_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Analog control outputs
	logic bandgap_next;
	logic high_pin_next;
	logic low_pin_next;
	logic ext_trip_next;
	logic irq_next;
	logic wake_next;

	// Bandgap follows every consumer; off only when none needs it
	assign bandgap_next = brownout_reset_enable || det_en_next
		|| high_en_next || low_en_next;

	// Pin drive needs its reference alive, else the pin stays general I/O
	assign high_pin_next = high_en_next && high_oe_next;
	assign low_pin_next = low_en_next && low_oe_next;

	// All ones code steers the comparator to the external pin
	assign ext_trip_next = (trip_next == refmon_pkg::TRIP_EXTERNAL);

	// Request level from flag and enable; wake only matters during sleep
	assign irq_next = flag_next && ie_next;
	assign wake_next = irq_next && sleep_active;

	// Power controls; built from next values, so they move with the registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bandgap_enable <= 1'b0;
			high_ref_amp_enable <= 1'b0;
			low_ref_amp_enable <= 1'b0;
			detector_power <= 1'b0;
		end else begin
			bandgap_enable <= bandgap_next;
			high_ref_amp_enable <= high_en_next;
			low_ref_amp_enable <= low_en_next;
			detector_power <= det_en_next;
		end
	end

	// Pin drive enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			high_ref_pin_out_enable <= 1'b0;
			low_ref_pin_out_enable <= 1'b0;
		end else begin
			high_ref_pin_out_enable <= high_pin_next;
			low_ref_pin_out_enable <= low_pin_next;
		end
	end

	// Trip selection towards the analog mux
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trip_level_select <= refmon_pkg::TRIP_RST;
			external_trip_select <= 1'b0;
		end else begin
			trip_level_select <= trip_next;
			external_trip_select <= ext_trip_next;
		end
	end

	// Request levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			droop_irq <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			droop_irq <= irq_next;
			wake_request <= wake_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path
	logic [31:0] rd_ref_word;
	logic [31:0] rd_lvd_word;
	logic [31:0] rd_droop_word;
	logic [31:0] rd_word;
	logic bandgap_stable_status_status_next;
	logic rd_hit_ref;
	logic rd_hit_lvd;
	logic rd_hit_droop;

	// Read from next values so a read right after a write sees the new data
	assign bandgap_stable_status_status_next = bandgap_stable_status_sync && bandgap_next;
	assign rd_ref_word = {24'h00_0000, high_en_next, low_en_next,
		high_oe_next, low_oe_next, 4'h0};
	assign rd_lvd_word = {24'h00_0000, 2'b00, bandgap_stable_status_status_next,
		det_en_next, trip_next};
	assign rd_droop_word = {30'h0000_0000, ie_next, flag_next};

	// Read hits decoded from the address phase offset
	assign rd_hit_ref = (rd_offset == refmon_pkg::OFF_REF_CTRL);
	assign rd_hit_lvd = (rd_offset == refmon_pkg::OFF_LVD_CTRL);
	assign rd_hit_droop = (rd_offset == refmon_pkg::OFF_DROOP_CTRL);

	// Unmapped offsets read as zero
	assign rd_word = rd_hit_ref ? rd_ref_word :
		rd_hit_lvd ? rd_lvd_word :
		rd_hit_droop ? rd_droop_word :
		refmon_pkg::RDATA_RST;

	// Zero wait state slave; read data held until the next read is taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= refmon_pkg::RDATA_RST;
			hreadyout <= 1'b1;
			hresp <= refmon_pkg::HRESP_OKAY;
		end else begin
			if (rd_accept) begin
				hrdata <= rd_word;
			end
			hreadyout <= 1'b1;
			hresp <= refmon_pkg::HRESP_OKAY;
		end
	end

endmodule // reference_and_supply_monitor_ctl

/* rtl/refmon_pkg.sv */
// Shared constants for the reference and supply monitor control block.
// Assumes a single core clock and an AHB-Lite master issuing single word transfers.
package refmon_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets and decode width
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_REF_CTRL = 8'h00;
	localparam logic [7:0] OFF_LVD_CTRL = 8'h04;
	localparam logic [7:0] OFF_DROOP_CTRL = 8'h08;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_HIGH_EN = 7;
	localparam int BIT_LOW_EN = 6;
	localparam int BIT_HIGH_OE = 5;
	localparam int BIT_LOW_OE = 4;
	localparam int BIT_DET_EN = 4;
	localparam int BIT_BANDGAP_STABLE_STATUS = 5;
	localparam int TRIP_LSB = 0;
	localparam int TRIP_W = 4;
	localparam int BIT_FLAG = 0;
	localparam int BIT_IE = 1;

	////////////////////////////////////////////////////////////////////////
	// Codes and values after reset
	localparam logic [3:0] TRIP_EXTERNAL = 4'hf;
	localparam logic [3:0] TRIP_RST = 4'h0;
	localparam logic ENABLE_RST = 1'b0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	localparam int SYNC_STAGES = 2;

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD = 3'b010;
	localparam logic HRESP_OKAY = 1'b0;

endpackage

/* verification/reference_and_supply_monitor_ctl_tb_top.sv */
// Self-checking bench for the reference and supply monitor control block.
// Drives the bus and analog-side inputs itself; no partner model.
`timescale 1ns/1ns
module reference_and_supply_monitor_ctl_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = refmon_pkg::HSIZE_WORD;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic brownout_reset_enable = 1'b0;
	logic bandgap_stable_async = 1'b0;
	logic droop_compare_async = 1'b0;
	logic sleep_active = 1'b0;
	wire hready, hreadyout, hresp, bandgap_enable, high_ref_amp_enable, low_ref_amp_enable;
	wire high_ref_pin_out_enable, low_ref_pin_out_enable, detector_power;
	wire external_trip_select, droop_irq, wake_request;
	wire [31:0] hrdata;
	wire [3:0] trip_level_select;
	int n_errors = 0;
	int n_compared = 0;
	logic [31:0] rd;
	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	wire [5:0] outs = {bandgap_enable, high_ref_amp_enable, low_ref_amp_enable,
		high_ref_pin_out_enable, low_ref_pin_out_enable, detector_power};
	reference_and_supply_monitor_ctl i_dut (.*);
	// Free-running 100 MHz clock
	initial forever #5 hclk = ~hclk;
	////////////////////////////////
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared=%0d errors=%0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Bounded wait; no fixed latency assumed
	task automatic edge_ready();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= refmon_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		edge_ready();
		htrans <= 2'b00;
		hwdata <= d;
		edge_ready();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Poll stable status; bounded, a run-out counts as a mismatch
	task automatic poll_stable();
		int k;
		k = 0;
		do begin
			bus(1'b0, 8'h04, 32'h0);
			k++;
		end while (rd[5] !== 1'b1 && k < 20);
		if (rd[5] !== 1'b1) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask
	////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(outs, 32'h0);
		rdchk(8'h00, 32'h0);
		rdchk(8'h04, 32'h0);
		rdchk(8'h08, 32'h0);
		wr(8'h00, 32'hffff_ffff);
		rdchk(8'h00, 32'hf0);
		chk(outs, 32'h3e);
		wr(8'h00, 32'h30);
		idle(2);
		chk(outs, 32'h0);
		wr(8'h00, 32'h50);
		idle(2);
		chk(outs, 32'h2a);
		wr(8'h00, 32'ha0);
		idle(2);
		chk(outs, 32'h34);
		wr(8'h00, 32'h80);
		idle(2);
		chk(outs, 32'h30);
		wr(8'h00, 32'h0);
		brownout_reset_enable <= 1'b1;
		idle(3);
		chk(outs, 32'h20);
		brownout_reset_enable <= 1'b0;
		idle(2);
		chk(outs, 32'h0);
		// Every trip code, external one last
		for (int i = 0; i < 16; i++) begin
			wr(8'h04, 32'(i));
			rdchk(8'h04, 32'(i));
			chk({external_trip_select, trip_level_select}, {(i == 15), i[3:0]});
		end
		wr(8'h04, 32'h03);
		wr(8'h04, 32'h13);
		wr(8'h08, 32'h02);
		droop_compare_async <= 1'b1;
		idle(6);
		rdchk(8'h08, 32'h02);
		rdchk(8'h04, 32'h13);
		chk(outs, 32'h21);
		bandgap_stable_async <= 1'b1;
		poll_stable();
		rdchk(8'h04, 32'h33);
		rdchk(8'h08, 32'h03);
		chk(droop_irq, 32'h1);
		sleep_active <= 1'b1;
		idle(2);
		chk(wake_request, 32'h1);
		sleep_active <= 1'b0;
		wr(8'h08, 32'h02);
		rdchk(8'h08, 32'h03);
		wr(8'h08, 32'h00);
		idle(2);
		chk({droop_irq, wake_request}, 32'h0);
		rdchk(8'h08, 32'h01);
		droop_compare_async <= 1'b0;
		idle(4);
		wr(8'h08, 32'h00);
		rdchk(8'h08, 32'h00);
		wr(8'h04, 32'h03);
		droop_compare_async <= 1'b1;
		idle(6);
		rdchk(8'h08, 32'h00);
		chk(outs, 32'h0);
		// Reset in mid-run with every power and pin enable on
		wr(8'h00, 32'hf0);
		wr(8'h04, 32'h1f);
		idle(2);
		chk(outs, 32'h3f);
		hresetn <= 1'b0;
		idle(2);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(outs, 32'h0);
		chk({external_trip_select, trip_level_select}, 32'h0);
		rdchk(8'h00, 32'h0);
		rdchk(8'h04, 32'h0);
		wr(8'h0c, 32'hff);
		rdchk(8'h0c, 32'h0);
		tally_and_finish();
	end
endmodule // reference_and_supply_monitor_ctl_tb_top

/* verification/refmon_asserts.sv */
// Checker for the reference and supply monitor control block.
// Sees only the top module ports; bound in below.
`timescale 1ns/1ns
module refmon_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] haddr,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic brownout_reset_enable,
	input wire logic sleep_active,
	input wire logic bandgap_enable,
	input wire logic high_ref_amp_enable,
	input wire logic low_ref_amp_enable,
	input wire logic high_ref_pin_out_enable,
	input wire logic low_ref_pin_out_enable,
	input wire logic detector_power,
	input wire logic [3:0] trip_level_select,
	input wire logic external_trip_select,
	input wire logic droop_irq,
	input wire logic wake_request
);
	// One domain, so clock and reset are given once
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire rd_ref = hsel && hready && htrans == refmon_pkg::HTRANS_NONSEQ && !hwrite
		&& hsize == refmon_pkg::HSIZE_WORD && haddr[7:0] == refmon_pkg::OFF_REF_CTRL;
	////////////////////////////////
	// Output relations
	AST_BANDGAP: assert property ($past(hresetn) |-> bandgap_enable ==
		($past(brownout_reset_enable) || high_ref_amp_enable || low_ref_amp_enable
		|| detector_power)) else $error("bandgap enable wrong");
	AST_HI_PIN: assert property (high_ref_pin_out_enable |-> high_ref_amp_enable)
		else $error("high pin enable without reference");
	AST_LO_PIN: assert property (low_ref_pin_out_enable |-> low_ref_amp_enable)
		else $error("low pin enable without reference");
	AST_EXT: assert property (external_trip_select ==
		(trip_level_select == refmon_pkg::TRIP_EXTERNAL)) else $error("external select wrong");
	AST_WAKE: assert property ($past(hresetn) |->
		wake_request == (droop_irq && $past(sleep_active))) else $error("wake wrong");
	AST_RST: assert property ($rose(hresetn) |-> trip_level_select == 4'h0
		&& !(high_ref_amp_enable || low_ref_amp_enable || detector_power || droop_irq))
		else $error("enables not clear after reset");
	// Unused bits of the reference control word must read zero on the next cycle
	AST_REF_RD: assert property (rd_ref |=> hrdata[3:0] == 4'h0
		&& hrdata[31:8] == 24'h0) else $error("reserved bits read nonzero");
	AST_BUS: assert property (hreadyout && hresp == refmon_pkg::HRESP_OKAY)
		else $error("bus response wrong");
	////////////////////////////////
	// Main scenarios reached
	COV_IRQ: cover property (droop_irq);
	COV_WAKE: cover property (wake_request);
	COV_EXT: cover property (external_trip_select);
endmodule // refmon_chk
bind reference_and_supply_monitor_ctl refmon_chk i_chk (.*);
